/* sim/bss_stage_model.sv */
// Behavioural power stage, feedback comparators and modulator around the sequencer
`timescale 1ns/1ps
module bss_stage_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Sequencer drive and output pre-bias level
    input wire logic high_side_en_i,
    input wire bss_pkg::bss_ref_t ref_dac_i,
    input wire bss_pkg::bss_ref_t prebias_i,
    // Comparators and modulator
    output logic ref_above_fb_o,
    output logic in_regulation_o,
    output logic hs_pulse_o
);
    import bss_pkg::*;
    bss_ref_t vout;
    logic [1:0] phase;
    // Output sits at its pre-bias level until switching makes it follow the reference
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            vout <= '0;
            phase <= '0;
            ref_above_fb_o <= 1'b0;
            in_regulation_o <= 1'b0;
            hs_pulse_o <= 1'b0;
        end else begin
            vout <= high_side_en_i ? ref_dac_i : prebias_i;
            phase <= phase + 2'h1;
            ref_above_fb_o <= (ref_dac_i > vout);
            in_regulation_o <= high_side_en_i && (ref_dac_i == 10'h320);
            hs_pulse_o <= high_side_en_i && (phase == 2'h0);
        end
    end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the start-up strap sequencer
`timescale 1ns/1ps
module testbench;
    import bss_pkg::*;
    localparam int INIT_N = 20;
    localparam int POD_N = 20;
    localparam int PG_N = 20;
    localparam int HIC_N = 30;
    localparam int STEP_N = 50;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic supply_good_i = 1'b0;
    logic enable_i = 1'b0;
    bss_ss_code_t ss_strap_code_i = 4'h0;
    logic ss_strap_open_i = 1'b0;
    bss_mode_code_t mode_strap_code_i = 3'h0;
    logic mode_strap_open_i = 1'b0;
    logic fault_i = 1'b0;
    logic forced_continuous_mode_write_i = 1'b0;
    logic forced_continuous_mode_data_i = 1'b0;
    bss_ref_t prebias = 10'h000;
    logic ref_above_fb_i, in_regulation_i, hs_pulse_i;
    logic high_side_en_o, low_side_en_o, power_good_out_o, power_good_out_oe_o;
    logic strap_valid_o, loop_comp_set_b_o, hiccup_sel_o, forced_continuous_mode_o;
    logic auto_skip_mode_o, forced_continuous_mode_ack_o, prev_hs, seen_hs;
    logic [1:0] soft_start_sel_o, switch_freq_sel_o;
    bss_ref_t ref_dac_o;
    logic [6:0] cfg;
    logic [31:0] seed = 32'hC9DC;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic mode_q[$];

    always #12.5 clock_i = ~clock_i;

    bss_sequencer #(.INIT_CYC(INIT_N), .POD_CYC(POD_N), .PG_CYC(PG_N), .HICCUP_CYC(HIC_N))
    bss_sequencer_i (.clock_i(clock_i), .reset_i(reset_i), .supply_good_i(supply_good_i),
        .enable_i(enable_i), .ss_strap_code_i(ss_strap_code_i), .ss_strap_open_i(ss_strap_open_i),
        .mode_strap_code_i(mode_strap_code_i), .mode_strap_open_i(mode_strap_open_i),
        .ref_above_fb_i(ref_above_fb_i), .in_regulation_i(in_regulation_i),
        .hs_pulse_i(hs_pulse_i), .fault_i(fault_i), .forced_continuous_mode_write_i(forced_continuous_mode_write_i),
        .forced_continuous_mode_data_i(forced_continuous_mode_data_i), .high_side_en_o(high_side_en_o),
        .low_side_en_o(low_side_en_o), .ref_dac_o(ref_dac_o),
        .power_good_out_o(power_good_out_o), .power_good_out_oe_o(power_good_out_oe_o),
        .strap_valid_o(strap_valid_o), .soft_start_sel_o(soft_start_sel_o),
        .loop_comp_set_b_o(loop_comp_set_b_o), .hiccup_sel_o(hiccup_sel_o),
        .switch_freq_sel_o(switch_freq_sel_o), .forced_continuous_mode_o(forced_continuous_mode_o),
        .auto_skip_mode_o(auto_skip_mode_o), .forced_continuous_mode_ack_o(forced_continuous_mode_ack_o));

    bss_stage_model bss_stage_model_i (.clock_i(clock_i), .reset_i(reset_i),
        .high_side_en_i(high_side_en_o), .ref_dac_i(ref_dac_o), .prebias_i(prebias),
        .ref_above_fb_o(ref_above_fb_i), .in_regulation_o(in_regulation_i),
        .hs_pulse_o(hs_pulse_i));

    assign cfg = {soft_start_sel_o, loop_comp_set_b_o, hiccup_sel_o, switch_freq_sel_o,
        forced_continuous_mode_o};

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Strap model: ss 16 and md 8 stand for a floating strap
    function automatic logic [6:0] exp_cfg(input int ss, input int md);
        int s;
        int m;
        s = (ss == 16) ? 2 : ss;
        m = (md == 8) ? 1 : md;
        return {2'(s % 4), 1'((s / 4) % 2), 1'(s / 8), 2'(m % 4), 1'(m / 4 == 0)};
    endfunction

    function automatic logic cond(input int sel);
        case (sel)
            0: return strap_valid_o === 1'b1;
            1: return ref_dac_o !== 10'h000;
            2: return ref_dac_o === 10'h320;
            3: return power_good_out_oe_o === 1'b0;
            4: return forced_continuous_mode_ack_o === 1'b1;
            default: return high_side_en_o === 1'b0;
        endcase
    endfunction

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge clock_i);
    endtask

    task automatic wait_n(input int sel, input int lim, output int cnt);
        cnt = 0;
        while (!cond(sel) && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask

    task automatic in_range(input int v, input int lo, input int hi, input string msg);
        check(v >= lo && v <= hi, msg);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Supply dip, new straps held stable through initialization, then moved after the latch
    task automatic power_up(input int ss, input int md);
        logic [6:0] want;
        want = exp_cfg(ss, md);
        supply_good_i = 1'b0;
        tick(2);
        check(strap_valid_o === 1'b0, "straps still valid after supply loss");
        ss_strap_code_i = 4'(ss % 16);
        ss_strap_open_i = (ss == 16);
        mode_strap_code_i = 3'(md % 8);
        mode_strap_open_i = (md == 8);
        supply_good_i = 1'b1;
        wait_n(0, 200, n);
        in_range(n, INIT_N, INIT_N + 3, "initialization length");
        check(cfg === want, "latched strap fields");
        check(auto_skip_mode_o === ~want[0], "skip mode not inverse");
        ss_strap_code_i = ~ss_strap_code_i;
        mode_strap_code_i = ~mode_strap_code_i;
        ss_strap_open_i = ~ss_strap_open_i;
        mode_strap_open_i = ~mode_strap_open_i;
        tick(3);
        check(cfg === want, "straps followed pins after latch");
    endtask

    // Pre-bias, low-side hold-off and timeout watch
    always @(negedge clock_i) begin
        cycles++;
        if (high_side_en_o === 1'b1 && prev_hs !== 1'b1 && ref_dac_o <= prebias)
            check(1'b0, "switching before reference passed feedback");
        if (high_side_en_o !== 1'b1)
            seen_hs = 1'b0;
        if (low_side_en_o === 1'b1 && seen_hs !== 1'b1)
            check(1'b0, "low side on before first high-side pulse");
        if (hs_pulse_i === 1'b1 && high_side_en_o === 1'b1)
            seen_hs = 1'b1;
        prev_hs = high_side_en_o;
        if (cycles >= 100000) begin
            n_errors++;
            $display("MISMATCH at %0t: run did not finish in time", $time);
            results();
        end
    end

    initial begin
        tick(12);
        reset_i = 1'b0;
        tick(1);
        check({high_side_en_o, low_side_en_o, power_good_out_o, strap_valid_o} === 4'h0,
            "reset outputs");
        check({ref_dac_o, power_good_out_oe_o} === {10'h000, 1'b1}, "reset ref or pg");
        for (int i = 0; i <= 16; i++) power_up(i, i % 9);
        repeat (3) power_up(int'(xs() % 16), int'(xs() % 8));
        $display("test straps done");
        power_up(0, 0);
        enable_i = 1'b1;
        tick(7);
        enable_i = 1'b0;
        tick(POD_N + STEP_N + 20);
        check(ref_dac_o === 10'h000, "short enable pulse started a ramp");
        prebias = 10'(50 + xs() % 250);
        enable_i = 1'b1;
        wait_n(1, 300, n);
        in_range(n, 8 + POD_N + STEP_N - 1, 8 + POD_N + STEP_N + 3, "power-on delay");
        check(ref_dac_o === 10'h001, "ramp did not start at zero");
        wait_n(2, 45000, n);
        in_range(n, 799 * STEP_N - 3, 799 * STEP_N + 3, "soft-start length");
        check(high_side_en_o === 1'b1, "no switching after ramp");
        wait_n(3, 300, n);
        in_range(n, PG_N - 1, PG_N + 3, "power-good delay");
        forced_continuous_mode_data_i = 1'b0;
        forced_continuous_mode_write_i = 1'b1;
        mode_q.push_back(1'b0);
        tick(1);
        forced_continuous_mode_write_i = 1'b0;
        wait_n(4, 3, n);
        check(n <= 1, "write not acknowledged");
        tick(3);
        check(forced_continuous_mode_o === 1'b1, "mode changed while enabled");
        enable_i = 1'b0;
        tick(7);
        enable_i = 1'b1;
        tick(10);
        check(high_side_en_o === 1'b1, "short low pulse stopped conversion");
        fault_i = 1'b1;
        tick(2);
        fault_i = 1'b0;
        tick(100);
        check({high_side_en_o, low_side_en_o, power_good_out_oe_o} === 3'b001,
            "latch-off released");
        enable_i = 1'b0;
        tick(12);
        check(forced_continuous_mode_o === mode_q.pop_front(), "mode not applied");
        check(cfg[6:1] === exp_cfg(0, 0) >> 1, "enable toggle changed straps");
        $display("test latch-off run done");
        prebias = 10'h000;
        enable_i = 1'b1;
        power_up(8, 5);
        wait_n(1, 300, n);
        in_range(n, POD_N + STEP_N - 3, POD_N + STEP_N + 3, "start held for init");
        wait_n(3, 45000, n);
        in_range(n, 799 * STEP_N + 19, 799 * STEP_N + 25, "ramp and power-good");
        fault_i = 1'b1;
        tick(2);
        fault_i = 1'b0;
        check({high_side_en_o, low_side_en_o, ref_dac_o} === 12'h000, "fault off");
        wait_n(1, 300, n);
        in_range(n, HIC_N + POD_N + STEP_N - 4, HIC_N + POD_N + STEP_N + 3, "restart");
        tick(20);
        enable_i = 1'b0;
        wait_n(5, 20, n);
        in_range(n, 7, 10, "shutdown delay");
        check({low_side_en_o, ref_dac_o} === 11'h000, "driver or ref left on");
        $display("test hiccup run done");
        results();
    end
endmodule

/* verilog/bss_cfg.svh */
// Timing, width, field and open-strap code constants for the start-up strap sequencer
`ifndef BSS_CFG_SVH
`define BSS_CFG_SVH
`define BSS_CLK_PERIOD_NS 25
`define BSS_INIT_TIME_US 300
`define BSS_POD_TIME_US 500
`define BSS_PG_DELAY_US 1000
`define BSS_HICCUP_TIME_MS 56
`define BSS_EN_DEGLITCH_NS 200
`define BSS_SS_BASE_MS 1
`define BSS_REF_FULL_MV 10'h320
`define BSS_REF_W 10
`define BSS_TMR_W 22
`define BSS_STEP_W 9
`define BSS_DEG_W 4
`define BSS_DEG_CYC ((`BSS_EN_DEGLITCH_NS + `BSS_CLK_PERIOD_NS - 1) / `BSS_CLK_PERIOD_NS)
`define BSS_SS_STEP_CYC ((`BSS_SS_BASE_MS * 1000000) / `BSS_CLK_PERIOD_NS / `BSS_REF_FULL_MV)
`define BSS_SS_TIME_LSB 0
`define BSS_SS_COMPB_BIT 2
`define BSS_SS_HICCUP_BIT 3
`define BSS_SS_OPEN_CODE 4'h2
`define BSS_MODE_FREQ_LSB 0
`define BSS_MODE_SKIP_BIT 2
`define BSS_MODE_OPEN_CODE 3'h1
`endif

/* verilog/bss_en_filter.sv */
// Enable deglitch filter
`timescale 1ns/1ps
`include "bss_cfg.svh"
module bss_en_filter (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Enable pin
    bss_en_if.filt en
);
    import bss_pkg::*;

    logic [`BSS_DEG_W-1:0] cnt;
    logic [`BSS_DEG_W-1:0] next_cnt;
    logic level;
    logic next_level;

    // A new level is taken only after it has held for the whole deglitch time
    always_comb begin
        next_level = level;
        next_cnt = '0;
        if (en.raw != level) begin
            if (cnt == `BSS_DEG_W'(`BSS_DEG_CYC - 1)) begin
                next_level = en.raw;
            end else begin
                next_cnt = cnt + `BSS_DEG_W'(1);
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cnt <= '0;
            level <= 1'b0;
        end else begin
            cnt <= next_cnt;
            level <= next_level;
        end
    end

    assign en.level = level;

    property p_en_filter;
        @(posedge clock_i) disable iff (reset_i)
        $changed(level) |-> $past(cnt) == `BSS_DEG_W'(`BSS_DEG_CYC - 1) && $past(en.raw) == level;
    endproperty
    a_en_filter: assert property (p_en_filter) else $error("enable changed before deglitch");
endmodule

/* verilog/bss_en_if.sv */
// Enable pin between the sequencer and its deglitch filter
`timescale 1ns/1ps
interface bss_en_if;
    logic raw;
    logic level;
    modport filt (input raw, output level);
    modport seq (output raw, input level);
endinterface

/* verilog/bss_pkg.sv */
// Types shared by the start-up strap sequencer
package bss_pkg;
`include "bss_cfg.svh"
    typedef enum logic [8:0] {
        ST_OFF    = 9'h001,
        ST_INIT   = 9'h002,
        ST_IDLE   = 9'h004,
        ST_POD    = 9'h008,
        ST_RAMP   = 9'h010,
        ST_PGDLY  = 9'h020,
        ST_RUN    = 9'h040,
        ST_LATCH  = 9'h080,
        ST_HICCUP = 9'h100
    } bss_state_e;
    typedef logic [`BSS_REF_W-1:0] bss_ref_t;
    typedef logic [`BSS_TMR_W-1:0] bss_tmr_t;
    typedef logic [3:0] bss_ss_code_t;
    typedef logic [2:0] bss_mode_code_t;
endpackage

/* verilog/bss_sequencer.sv */
// Start-up, shutdown and strap capture sequencer for a step-down converter
`timescale 1ns/1ps
`include "bss_cfg.svh"
module bss_sequencer #(
    parameter int unsigned INIT_CYC = (`BSS_INIT_TIME_US * 1000) / `BSS_CLK_PERIOD_NS,
    parameter int unsigned POD_CYC = (`BSS_POD_TIME_US * 1000) / `BSS_CLK_PERIOD_NS,
    parameter int unsigned PG_CYC = (`BSS_PG_DELAY_US * 1000) / `BSS_CLK_PERIOD_NS,
    parameter int unsigned HICCUP_CYC = (`BSS_HICCUP_TIME_MS * 1000000) / `BSS_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Supply monitor and enable pin
    input wire logic supply_good_i,
    input wire logic enable_i,
    // Decoded straps
    input wire bss_pkg::bss_ss_code_t ss_strap_code_i,
    input wire logic ss_strap_open_i,
    input wire bss_pkg::bss_mode_code_t mode_strap_code_i,
    input wire logic mode_strap_open_i,
    // Regulation comparators and modulator
    input wire logic ref_above_fb_i,
    input wire logic in_regulation_i,
    input wire logic hs_pulse_i,
    input wire logic fault_i,
    // Forced-continuous bit write
    input wire logic forced_continuous_mode_write_i,
    input wire logic forced_continuous_mode_data_i,
    // Gate drivers and reference DAC
    output logic high_side_en_o,
    output logic low_side_en_o,
    output bss_pkg::bss_ref_t ref_dac_o,
    // Open-drain power-good
    output logic power_good_out_o,
    output logic power_good_out_oe_o,
    // Latched configuration
    output logic strap_valid_o,
    output logic [1:0] soft_start_sel_o,
    output logic loop_comp_set_b_o,
    output logic hiccup_sel_o,
    output logic [1:0] switch_freq_sel_o,
    output logic forced_continuous_mode_o,
    output logic auto_skip_mode_o,
    output logic forced_continuous_mode_ack_o
);
    import bss_pkg::*;
    bss_en_if en_bus ();
    assign en_bus.raw = enable_i;
    bss_en_filter u_en_filter (.clock_i(clock_i), .reset_i(reset_i), .en(en_bus.filt));
    wire logic en_level = en_bus.level;
    bss_state_e state, next_state;
    bss_tmr_t tmr, next_tmr;
    logic [`BSS_STEP_W-1:0] step, next_step;
    bss_ref_t ref_code, next_ref;
    logic switching, next_switching;
    logic hs_seen, next_hs_seen;
    logic hs_en, next_hs_en;
    logic ls_en, next_ls_en;
    logic pg_pull, next_pg_pull;
    logic strap_valid, next_strap_valid;
    logic [1:0] ss_sel, next_ss_sel;
    logic comp_b, next_comp_b;
    logic hiccup, next_hiccup;
    logic [1:0] freq_sel, next_freq_sel;
    logic forced_continuous_mode_act, next_forced_continuous_mode_act;
    logic forced_continuous_mode_pend, next_forced_continuous_mode_pend;
    logic ack, next_ack;
    logic auto_skip, next_auto_skip;
    logic pg_out;
    logic [`BSS_STEP_W-1:0] step_lim;
    bss_ss_code_t ss_code;
    bss_mode_code_t mode_code;
    logic converting;
    // Open straps fall back to their default codes
    assign ss_code = ss_strap_open_i ? `BSS_SS_OPEN_CODE : ss_strap_code_i;
    assign mode_code = mode_strap_open_i ? `BSS_MODE_OPEN_CODE : mode_strap_code_i;
    // Ramp step doubles with each soft-start code
    assign step_lim = `BSS_STEP_W'(`BSS_SS_STEP_CYC) << ss_sel;
    assign converting = state inside {ST_POD, ST_RAMP, ST_PGDLY, ST_RUN, ST_LATCH, ST_HICCUP};
    always_comb begin
        next_state = state;
        next_tmr = tmr + `BSS_TMR_W'(1);
        next_step = step;
        next_ref = ref_code;
        next_switching = switching;
        next_hs_seen = hs_seen;
        next_pg_pull = pg_pull;
        next_strap_valid = strap_valid;
        next_ss_sel = ss_sel;
        next_comp_b = comp_b;
        next_hiccup = hiccup;
        next_freq_sel = freq_sel;
        next_forced_continuous_mode_act = forced_continuous_mode_act;
        next_forced_continuous_mode_pend = forced_continuous_mode_pend;
        next_ack = forced_continuous_mode_write_i;
        if (forced_continuous_mode_write_i) begin
            next_forced_continuous_mode_pend = forced_continuous_mode_data_i;
        end
        case (state)
            ST_OFF: begin
                next_tmr = '0;
                if (supply_good_i) begin
                    next_state = ST_INIT;
                end
            end
            ST_INIT: begin
                if (tmr == `BSS_TMR_W'(INIT_CYC - 1)) begin
                    next_state = ST_IDLE;
                    next_tmr = '0;
                    next_strap_valid = 1'b1;
                    next_ss_sel = ss_code[`BSS_SS_TIME_LSB +: 2];
                    next_comp_b = ss_code[`BSS_SS_COMPB_BIT];
                    next_hiccup = ss_code[`BSS_SS_HICCUP_BIT];
                    next_freq_sel = mode_code[`BSS_MODE_FREQ_LSB +: 2];
                    next_forced_continuous_mode_act = ~mode_code[`BSS_MODE_SKIP_BIT];
                    next_forced_continuous_mode_pend = ~mode_code[`BSS_MODE_SKIP_BIT];
                end
            end
            ST_IDLE: begin
                next_tmr = '0;
                next_forced_continuous_mode_act = next_forced_continuous_mode_pend;
                if (en_level) begin
                    next_state = ST_POD;
                end
            end
            ST_POD: begin
                if (tmr == `BSS_TMR_W'(POD_CYC - 1)) begin
                    next_state = ST_RAMP;
                    next_step = '0;
                    next_ref = '0;
                end
            end
            ST_RAMP: begin
                next_step = step + `BSS_STEP_W'(1);
                if (step >= step_lim - `BSS_STEP_W'(1)) begin
                    next_step = '0;
                    if (ref_code != `BSS_REF_FULL_MV) begin
                        next_ref = ref_code + `BSS_REF_W'(1);
                    end
                end
                if (ref_above_fb_i) begin
                    next_switching = 1'b1;
                end
                if (ref_code == `BSS_REF_FULL_MV && in_regulation_i) begin
                    next_state = ST_PGDLY;
                    next_tmr = '0;
                end
            end
            ST_PGDLY, ST_RUN: begin
                if (fault_i) begin
                    next_state = hiccup ? ST_HICCUP : ST_LATCH;
                    next_tmr = '0;
                    next_switching = 1'b0;
                    next_ref = '0;
                    next_pg_pull = 1'b1;
                end else if (state == ST_PGDLY && tmr == `BSS_TMR_W'(PG_CYC - 1)) begin
                    next_state = ST_RUN;
                    next_pg_pull = 1'b0;
                end
            end
            ST_LATCH: next_tmr = '0;
            ST_HICCUP: begin
                if (tmr == `BSS_TMR_W'(HICCUP_CYC - 1)) begin
                    next_state = ST_POD;
                    next_tmr = '0;
                end
            end
            default: begin
                next_state = ST_OFF;
                next_tmr = '0;
            end
        endcase
        // Enable low ends conversion and clears a latched fault, straps untouched
        if (!en_level && converting) begin
            next_state = ST_IDLE;
            next_switching = 1'b0;
            next_ref = '0;
            next_pg_pull = 1'b1;
            next_tmr = '0;
        end
        // Loss of supply-good drops everything, straps included
        if (!supply_good_i) begin
            next_state = ST_OFF;
            next_strap_valid = 1'b0;
            next_switching = 1'b0;
            next_ref = '0;
            next_pg_pull = 1'b1;
            next_tmr = '0;
        end
        next_hs_seen = next_switching && (hs_seen || hs_pulse_i);
        next_hs_en = next_switching;
        next_ls_en = next_switching && next_hs_seen;
        next_auto_skip = ~next_forced_continuous_mode_act;
    end
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_OFF;
            tmr <= '0;
            step <= '0;
            ref_code <= '0;
            switching <= 1'b0;
            hs_seen <= 1'b0;
            hs_en <= 1'b0;
            ls_en <= 1'b0;
            pg_pull <= 1'b1;
            pg_out <= 1'b0;
            strap_valid <= 1'b0;
            ss_sel <= 2'h0;
            comp_b <= 1'b0;
            hiccup <= 1'b0;
            freq_sel <= 2'h0;
            forced_continuous_mode_act <= 1'b1;
            forced_continuous_mode_pend <= 1'b1;
            ack <= 1'b0;
            auto_skip <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            step <= next_step;
            ref_code <= next_ref;
            switching <= next_switching;
            hs_seen <= next_hs_seen;
            hs_en <= next_hs_en;
            ls_en <= next_ls_en;
            pg_pull <= next_pg_pull;
            pg_out <= 1'b0;
            strap_valid <= next_strap_valid;
            ss_sel <= next_ss_sel;
            comp_b <= next_comp_b;
            hiccup <= next_hiccup;
            freq_sel <= next_freq_sel;
            forced_continuous_mode_act <= next_forced_continuous_mode_act;
            forced_continuous_mode_pend <= next_forced_continuous_mode_pend;
            ack <= next_ack;
            auto_skip <= next_auto_skip;
        end
    end
    assign high_side_en_o = hs_en;
    assign low_side_en_o = ls_en;
    assign ref_dac_o = ref_code;
    assign power_good_out_o = pg_out;
    assign power_good_out_oe_o = pg_pull;
    assign strap_valid_o = strap_valid;
    assign soft_start_sel_o = ss_sel;
    assign loop_comp_set_b_o = comp_b;
    assign hiccup_sel_o = hiccup;
    assign switch_freq_sel_o = freq_sel;
    assign forced_continuous_mode_o = forced_continuous_mode_act;
    assign auto_skip_mode_o = auto_skip;
    assign forced_continuous_mode_ack_o = ack;
    sequence s_en_drop;
        !en_level && converting && supply_good_i;
    endsequence
    sequence s_drivers_off;
        !high_side_en_o && !low_side_en_o && ref_dac_o == '0;
    endsequence
    property p_init_len;
        @(posedge clock_i) disable iff (reset_i)
        state == ST_INIT && next_state == ST_IDLE |-> tmr == `BSS_TMR_W'(INIT_CYC - 1);
    endproperty
    a_init_len: assert property (p_init_len) else $error("init length wrong");
    property p_strap_hold;
        @(posedge clock_i) disable iff (reset_i)
        strap_valid && $past(strap_valid) |-> $stable(ss_sel) && $stable(comp_b)
            && $stable(hiccup) && $stable(freq_sel);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
    property p_pod_needs_strap;
        @(posedge clock_i) disable iff (reset_i)
        $rose(state == ST_POD) && $past(state) == ST_IDLE |-> strap_valid && $past(en_level);
    endproperty
    a_pod_needs_strap: assert property (p_pod_needs_strap) else $error("start before init");
    property p_shutdown;
        @(posedge clock_i) disable iff (reset_i)
        s_en_drop |=> s_drivers_off ##0 state == ST_IDLE;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not immediate");
    property p_ref_zero_idle;
        @(posedge clock_i) disable iff (reset_i)
        state == ST_IDLE |-> ref_dac_o == '0 && power_good_out_oe_o;
    endproperty
    a_ref_zero_idle: assert property (p_ref_zero_idle) else $error("reference not cleared");
    property p_prebias;
        @(posedge clock_i) disable iff (reset_i)
        $rose(high_side_en_o) |-> $past(ref_above_fb_i) && !low_side_en_o;
    endproperty
    a_prebias: assert property (p_prebias) else $error("switching before ref passes fb");
    property p_low_after_high;
        @(posedge clock_i) disable iff (reset_i)
        $rose(low_side_en_o) |-> high_side_en_o && ($past(hs_pulse_i) || $past(hs_seen));
    endproperty
    a_low_after_high: assert property (p_low_after_high) else $error("low side too early");
    property p_pg_delay;
        @(posedge clock_i) disable iff (reset_i)
        $fell(power_good_out_oe_o) |-> $past(state) == ST_PGDLY
            && $past(tmr) == `BSS_TMR_W'(PG_CYC - 1);
    endproperty
    a_pg_delay: assert property (p_pg_delay) else $error("power-good timing wrong");
    property p_forced_continuous_mode_frozen;
        @(posedge clock_i) disable iff (reset_i)
        $changed(forced_continuous_mode_o) |-> $past(state) == ST_IDLE || $past(state) == ST_INIT;
    endproperty
    a_forced_continuous_mode_frozen: assert property (p_forced_continuous_mode_frozen) else $error("mode changed while enabled");
    property p_hiccup_len;
        @(posedge clock_i) disable iff (reset_i)
        state == ST_HICCUP && next_state == ST_POD |-> tmr == `BSS_TMR_W'(HICCUP_CYC - 1);
    endproperty
    a_hiccup_len: assert property (p_hiccup_len) else $error("hiccup time wrong");
    property p_latch_hold;
        @(posedge clock_i) disable iff (reset_i)
        state == ST_LATCH && en_level && supply_good_i |=> state == ST_LATCH && !high_side_en_o;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch-off released");
endmodule
